// file: logic/osc_consts.svh
// Constants for the oscillator control register block.
// Assumes inclusion by bare name from the logic folder.
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH
// Register addresses
`define OSC_ADDR_CONTROL 2'h0
`define OSC_ADDR_STATUS 2'h1
`define OSC_ADDR_TUNING 2'h2
// Control register fields
`define OSC_CTL_MULT_BIT 7
`define OSC_CTL_FSEL_HI 6
`define OSC_CTL_FSEL_LO 3
`define OSC_CTL_SCS_HI 1
`define OSC_CTL_SCS_LO 0
// Reset values
`define OSC_FSEL_RESET 4'h7
`define OSC_SCS_RESET 2'h0
`define OSC_TRIM_RESET 6'h00
// Tuning register trim field
`define OSC_TRIM_HI 5
`define OSC_TRIM_LO 0
// Status bit positions
`define OSC_ST_SEC_READY 7
`define OSC_ST_MULT_READY 6
`define OSC_ST_CONFIGURED 5
`define OSC_ST_HF_READY 4
`define OSC_ST_HF_LOCKED 3
`define OSC_ST_MF_READY 2
`define OSC_ST_LF_READY 1
`define OSC_ST_HF_STABLE 0
// Start-up timer oscillation count
`define OSC_STARTUP_COUNT 11'h400
// Configured modes that need the start-up timer (crystal and resonator)
`define OSC_MODE_LP 3'h0
`define OSC_MODE_XT 3'h1
`define OSC_MODE_HS 3'h2
`endif

// file: logic/osc_pkg.sv
// Types shared by the oscillator control register block.
// Assumes nothing of its surroundings.
package osc_pkg;
	// Source feeding the system clock
	typedef enum logic [3:0] {
		OSC_SRC_CONFIGURED = 4'h1,
		OSC_SRC_SECONDARY = 4'h2,
		OSC_SRC_INTERNAL = 4'h4,
		OSC_SRC_STARTUP = 4'h8
	} osc_src_t;
	// Internal oscillator chosen by the frequency field
	typedef enum logic [1:0] {
		OSC_INT_HF = 2'h0,
		OSC_INT_MF = 2'h1,
		OSC_INT_LF = 2'h2
	} osc_int_t;
endpackage : osc_pkg

// file: logic/osc_startup_timer.sv
// Start-up timer counting oscillations of the configured oscillator.
// Assumes osc_edge is already synchronised to clk, one pulse per oscillation.
`timescale 1ns/1ps
`default_nettype none
`include "osc_consts.svh"
module osc_startup_timer
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic restart,
	input wire logic osc_edge,
	output logic done
);
	logic [10:0] count;

	always_ff @(posedge clk)
	begin
		if (!rst_b || restart)
		begin
			count <= 11'h000;
			done <= 1'b0;
		end
		else if (osc_edge && !done)
		begin
			count <= count + 11'h001;
			done <= (count + 11'h001) == `OSC_STARTUP_COUNT; // [RULE_16]
		end
	end
endmodule : osc_startup_timer
`default_nettype wire

// file: logic/osc_ctrl.sv
// Oscillator control, status and tuning registers with clock selection.
// Assumes a plain register port on clk; oscillator readiness inputs are
// asynchronous and configuration inputs are static after reset.
//
// Summary of operation
// RULE_01: Configured multiplier enable forces multiplier on
// RULE_02: Else software bit enables the multiplier
// RULE_03: Codes 1111..1000 pick halving high-frequency rates
// RULE_04: Code 1110 gives 8 or 32 MHz
// RULE_05: Mid and low codes; field resets 0111
// RULE_06: Duplicate rates come from high-frequency oscillator
// RULE_07: Control bit 2 reads zero
// RULE_08: Clock select routes internal, secondary, configured
// RULE_09: Secondary ready, or one when timer disabled
// RULE_10: Status bit 6 shows multiplier ready
// RULE_11: Status bit 5 shows configured clock running
// RULE_12: Status bits 4,2,1 show oscillator readiness
// RULE_13: Status bit 3 shows 2% lock
// RULE_14: Status bit 0 shows 0.5% stability
// RULE_15: Six-bit two's-complement trim field
// RULE_16: Crystal modes wait 1024 oscillations first
// RULE_17: Failure fallback uses frequency select choice
// RULE_18: Status register writes have no effect
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "osc_consts.svh"
module osc_ctrl
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic cfg_multiplier_enable,
	input wire logic [2:0] cfg_oscillator_mode,
	input wire logic timer_secondary_osc_enable,
	input wire logic configured_osc_edge,
	input wire logic clock_failure_monitor,
	input wire logic secondary_osc_ready,
	input wire logic multiplier_ready,
	input wire logic high_freq_osc_ready,
	input wire logic high_freq_osc_locked,
	input wire logic mid_freq_osc_ready,
	input wire logic low_freq_osc_ready,
	input wire logic high_freq_osc_stable,
	output logic multiplier_on,
	output osc_pkg::osc_src_t clock_source,
	output osc_pkg::osc_int_t internal_osc,
	output logic [4:0] internal_div_log2,
	output logic [5:0] freq_trim_out
);
	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic soft_multiplier_enable;
	logic [3:0] internal_freq_select;
	logic [1:0] system_clock_select;
	logic [5:0] freq_trim;
	logic [7:0] sync_a;
	logic [7:0] sync_b;
	logic [1:0] edge_sync;
	logic edge_prev;
	logic osc_edge;
	logic scs_changed;
	logic startup_done;
	logic crystal_mode;
	logic [7:0] status_now;
	osc_pkg::osc_src_t next_source;
	osc_pkg::osc_int_t next_internal;
	logic [4:0] next_div;

	// ------------------------------------------------------------
	// Control and tuning writes
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			soft_multiplier_enable <= 1'b0;
			internal_freq_select <= `OSC_FSEL_RESET; // [RULE_05]
			system_clock_select <= `OSC_SCS_RESET;
		end
		else if (reg_write && reg_addr == `OSC_ADDR_CONTROL)
		begin
			soft_multiplier_enable <= reg_wdata[`OSC_CTL_MULT_BIT];
			internal_freq_select <= reg_wdata[`OSC_CTL_FSEL_HI:`OSC_CTL_FSEL_LO];
			system_clock_select <= reg_wdata[`OSC_CTL_SCS_HI:`OSC_CTL_SCS_LO];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			freq_trim <= `OSC_TRIM_RESET;
		else if (reg_write && reg_addr == `OSC_ADDR_TUNING)
			freq_trim <= reg_wdata[`OSC_TRIM_HI:`OSC_TRIM_LO]; // [RULE_15]
	end

	// ------------------------------------------------------------
	// Synchronisers for oscillator status inputs
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			sync_a <= 8'h00;
			sync_b <= 8'h00;
			edge_sync <= 2'h0;
			edge_prev <= 1'b0;
		end
		else
		begin
			sync_a <= {secondary_osc_ready, multiplier_ready, clock_failure_monitor,
				high_freq_osc_ready, high_freq_osc_locked, mid_freq_osc_ready,
				low_freq_osc_ready, high_freq_osc_stable};
			sync_b <= sync_a;
			edge_sync <= {edge_sync[0], configured_osc_edge};
			edge_prev <= edge_sync[1];
		end
	end

	assign osc_edge = edge_sync[1] && !edge_prev;

	// ------------------------------------------------------------
	// Start-up timer, restarted by a clock select change
	// ------------------------------------------------------------
	assign scs_changed = reg_write && reg_addr == `OSC_ADDR_CONTROL
		&& reg_wdata[`OSC_CTL_SCS_HI:`OSC_CTL_SCS_LO] != system_clock_select;
	assign crystal_mode = cfg_oscillator_mode == `OSC_MODE_LP
		|| cfg_oscillator_mode == `OSC_MODE_XT || cfg_oscillator_mode == `OSC_MODE_HS;

	osc_startup_timer u_startup
	(
		.clk(clk),
		.rst_b(rst_b),
		.restart(scs_changed),
		.osc_edge(osc_edge),
		.done(startup_done)
	);

	// ------------------------------------------------------------
	// Frequency decode
	// ------------------------------------------------------------
	always_comb
	begin
		next_internal = osc_pkg::OSC_INT_LF;
		next_div = 5'h00;
		case (internal_freq_select)
			4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'hA, 4'h9, 4'h8:
			begin
				// 16 MHz halved per step below 1111 [RULE_03] [RULE_06]
				next_internal = osc_pkg::OSC_INT_HF;
				next_div = 5'(4'hF - internal_freq_select);
				// 1110 with the software multiplier bit gives 32 MHz [RULE_04]
				if (internal_freq_select == 4'hE && soft_multiplier_enable)
					next_div = 5'h1F;
			end
			4'h7, 4'h6, 4'h5, 4'h4:
			begin
				// 500 kHz halved per step [RULE_05]
				next_internal = osc_pkg::OSC_INT_MF;
				next_div = 5'(4'h7 - internal_freq_select);
			end
			4'h3:
			begin
				// 31.25 kHz from the high-frequency oscillator [RULE_06]
				next_internal = osc_pkg::OSC_INT_HF;
				next_div = 5'h09;
			end
			4'h2:
			begin
				next_internal = osc_pkg::OSC_INT_MF;
				next_div = 5'h04; // [RULE_05]
			end
			default:
			begin
				next_internal = osc_pkg::OSC_INT_LF; // [RULE_05]
				next_div = 5'h00;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Clock source selection
	// ------------------------------------------------------------
	always_comb
	begin
		next_source = osc_pkg::OSC_SRC_INTERNAL;
		case (system_clock_select)
			2'h2, 2'h3: next_source = osc_pkg::OSC_SRC_INTERNAL; // [RULE_08]
			2'h1: next_source = osc_pkg::OSC_SRC_SECONDARY; // [RULE_08]
			2'h0:
			begin
				// Crystal modes select the start-up source until start-up completes [RULE_16]
				if (crystal_mode && !startup_done)
					next_source = osc_pkg::OSC_SRC_STARTUP;
				else
					next_source = osc_pkg::OSC_SRC_CONFIGURED; // [RULE_08]
			end
			default: next_source = osc_pkg::OSC_SRC_INTERNAL;
		endcase
		// Failed external clock falls back to the selected internal one [RULE_17]
		if (sync_b[5] && next_source != osc_pkg::OSC_SRC_INTERNAL)
			next_source = osc_pkg::OSC_SRC_INTERNAL;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			clock_source <= osc_pkg::OSC_SRC_INTERNAL;
			internal_osc <= osc_pkg::OSC_INT_MF;
			internal_div_log2 <= 5'h00;
			multiplier_on <= 1'b0;
			freq_trim_out <= `OSC_TRIM_RESET;
		end
		else
		begin
			clock_source <= next_source;
			internal_osc <= next_internal; // [RULE_17]
			internal_div_log2 <= next_div;
			multiplier_on <= cfg_multiplier_enable || soft_multiplier_enable; // [RULE_01] [RULE_02]
			freq_trim_out <= freq_trim; // [RULE_15]
		end
	end

	// ------------------------------------------------------------
	// Status assembly and read port
	// ------------------------------------------------------------
	always_comb
	begin
		status_now = 8'h00;
		status_now[`OSC_ST_SEC_READY] = !timer_secondary_osc_enable || sync_b[7]; // [RULE_09]
		status_now[`OSC_ST_MULT_READY] = sync_b[6]; // [RULE_10]
		status_now[`OSC_ST_CONFIGURED] = clock_source == osc_pkg::OSC_SRC_CONFIGURED; // [RULE_11]
		status_now[`OSC_ST_HF_READY] = sync_b[4]; // [RULE_12]
		status_now[`OSC_ST_HF_LOCKED] = sync_b[3]; // [RULE_13]
		status_now[`OSC_ST_MF_READY] = sync_b[2]; // [RULE_12]
		status_now[`OSC_ST_LF_READY] = sync_b[1]; // [RULE_12]
		status_now[`OSC_ST_HF_STABLE] = sync_b[0]; // [RULE_14]
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			reg_rdata <= 8'h00;
		else if (reg_read)
		begin
			case (reg_addr)
				`OSC_ADDR_CONTROL: reg_rdata <= {soft_multiplier_enable,
					internal_freq_select, 1'b0, system_clock_select}; // [RULE_07]
				`OSC_ADDR_STATUS: reg_rdata <= status_now; // [RULE_18]
				`OSC_ADDR_TUNING: reg_rdata <= {2'h0, freq_trim};
				default: reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence seq_ctl_read;
		reg_read && reg_addr == `OSC_ADDR_CONTROL;
	endsequence

	AST_MULT_FORCED: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_01]
		cfg_multiplier_enable |=> multiplier_on)
		else $error("multiplier not forced on");
	AST_MULT_SOFT: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_02]
		!cfg_multiplier_enable |=> multiplier_on == $past(soft_multiplier_enable))
		else $error("multiplier does not follow software bit");
	AST_CTL_BIT2: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_07]
		seq_ctl_read |=> !reg_rdata[2])
		else $error("control bit 2 not zero");
	AST_HF_DIV: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03]
		internal_freq_select == 4'hD |=> internal_osc == osc_pkg::OSC_INT_HF
			&& internal_div_log2 == 5'h02)
		else $error("code 1101 not 4 MHz");
	AST_LF_SEL: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_05]
		internal_freq_select[3:1] == 3'h0 |=> internal_osc == osc_pkg::OSC_INT_LF)
		else $error("low code not low oscillator");
	AST_SEC_READY: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_09]
		reg_read && reg_addr == `OSC_ADDR_STATUS && !timer_secondary_osc_enable
			|=> reg_rdata[7])
		else $error("secondary ready not one");
	AST_SCS_INT: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_08]
		system_clock_select[1] |=> clock_source == osc_pkg::OSC_SRC_INTERNAL)
		else $error("internal select not routed");
	AST_STATUS_RO: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_18]
		reg_write && reg_addr == `OSC_ADDR_STATUS |=> $stable(freq_trim)
			&& $stable(internal_freq_select))
		else $error("status write changed state");

	// Status bits trail their pins by three edges
	sequence seq_status_read;
		reg_read && reg_addr == `OSC_ADDR_STATUS;
	endsequence

	sequence seq_tune_write;
		reg_write && reg_addr == `OSC_ADDR_TUNING;
	endsequence

	AST_SEC_TRACK: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_09]
		seq_status_read ##0 timer_secondary_osc_enable |=> reg_rdata[`OSC_ST_SEC_READY] == $past(secondary_osc_ready, 3))
		else $error("secondary ready does not track pin");
	AST_MULT_READY: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_10]
		seq_status_read |=> reg_rdata[`OSC_ST_MULT_READY] == $past(multiplier_ready, 3))
		else $error("multiplier ready bit wrong");
	AST_CONFIGURED_BIT: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_11]
		seq_status_read |=> reg_rdata[`OSC_ST_CONFIGURED] == ($past(clock_source) == osc_pkg::OSC_SRC_CONFIGURED))
		else $error("configured clock bit wrong");
	AST_OSC_READY: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_12]
		seq_status_read |=> reg_rdata[`OSC_ST_HF_READY] == $past(high_freq_osc_ready, 3)
			&& reg_rdata[`OSC_ST_MF_READY] == $past(mid_freq_osc_ready, 3)
			&& reg_rdata[`OSC_ST_LF_READY] == $past(low_freq_osc_ready, 3))
		else $error("oscillator ready bits wrong");
	AST_HF_LOCKED: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_13]
		seq_status_read |=> reg_rdata[`OSC_ST_HF_LOCKED] == $past(high_freq_osc_locked, 3))
		else $error("lock bit wrong");
	AST_HF_STABLE: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_14]
		seq_status_read |=> reg_rdata[`OSC_ST_HF_STABLE] == $past(high_freq_osc_stable, 3))
		else $error("stable bit wrong");
	AST_TRIM_OUT: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_15]
		seq_tune_write |=> ##1 freq_trim_out == $past(reg_wdata[`OSC_TRIM_HI:`OSC_TRIM_LO], 2))
		else $error("trim output does not follow write");
	AST_MULT32: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_04]
		internal_freq_select == 4'hE && soft_multiplier_enable |=> internal_osc == osc_pkg::OSC_INT_HF && internal_div_log2 == 5'h1F)
		else $error("code 1110 with multiplier not 32 MHz");
	AST_DUP_LOW: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_06]
		internal_freq_select == 4'h3 |=> internal_osc == osc_pkg::OSC_INT_HF && internal_div_log2 == 5'h09)
		else $error("code 0011 not from high-frequency oscillator");
	AST_MF_LOW: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_05]
		internal_freq_select == 4'h2 |=> internal_osc == osc_pkg::OSC_INT_MF && internal_div_log2 == 5'h04)
		else $error("code 0010 not mid oscillator 31.25 kHz");
	AST_STARTUP_HOLD: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_16]
		system_clock_select == 2'h0 && crystal_mode && !startup_done && !sync_b[5] |=> clock_source == osc_pkg::OSC_SRC_STARTUP)
		else $error("configured clock used before start-up count");
	AST_FAIL_FALLBACK: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_17]
		sync_b[5] |=> clock_source == osc_pkg::OSC_SRC_INTERNAL)
		else $error("failure did not fall back to internal clock");
endmodule : osc_ctrl
`default_nettype wire

// file: tb/test_osc_ctrl.sv
// Self-checking bench for the oscillator control register block.
// Assumes osc_pkg and osc_ctrl are compiled first; the bench drives every input.
`timescale 1ns/1ps
`default_nettype none
module test_osc_ctrl;
	logic clk, rst_b, reg_write, reg_read, cfg_mult, tmr_en, osc_edge, fail, multiplier_on;
	logic [1:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rv;
	logic [2:0] mode;
	logic [6:0] rdy;
	logic [4:0] div;
	logic [5:0] trim;
	osc_pkg::osc_src_t clock_source;
	osc_pkg::osc_int_t internal_osc;
	int n_fail, comparisons;

	osc_ctrl dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.cfg_multiplier_enable(cfg_mult), .cfg_oscillator_mode(mode),
		.timer_secondary_osc_enable(tmr_en), .configured_osc_edge(osc_edge),
		.clock_failure_monitor(fail), .secondary_osc_ready(rdy[6]),
		.multiplier_ready(rdy[5]), .high_freq_osc_ready(rdy[4]),
		.high_freq_osc_locked(rdy[3]), .mid_freq_osc_ready(rdy[2]),
		.low_freq_osc_ready(rdy[1]), .high_freq_osc_stable(rdy[0]),
		.multiplier_on(multiplier_on), .clock_source(clock_source),
		.internal_osc(internal_osc), .internal_div_log2(div), .freq_trim_out(trim));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------
	task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task give_verdict;
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr

	task rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask : rd

	task do_reset(input logic m, input logic [2:0] md);
		@(posedge clk);
		rst_b <= 1'b0;
		cfg_mult <= m;
		mode <= md;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
	endtask : do_reset

	task wait_src(input osc_pkg::osc_src_t exp, input int lim);
		int i;
		for (i = 0; i < lim && clock_source !== exp; i++)
			@(negedge clk);
		chk(8'(clock_source), 8'(exp), "clock source");
		if (i == lim)
			give_verdict();
	endtask : wait_src

	task edges(input int n);
		repeat (n)
		begin
			@(posedge clk);
			osc_edge <= 1'b1;
			repeat (2) @(posedge clk);
			osc_edge <= 1'b0;
			@(posedge clk);
		end
	endtask : edges

	// Expected {internal_osc, div} for a frequency code
	function automatic logic [6:0] exp_freq(input logic [3:0] c, input logic s);
		if (c == 4'hE && s)
			return {2'h0, 5'h1F};
		if (c >= 4'h8)
			return {2'h0, 5'(4'hF - c)};
		if (c >= 4'h4)
			return {2'h1, 5'(4'h7 - c)};
		if (c == 4'h3)
			return {2'h0, 5'h09};
		if (c == 4'h2)
			return {2'h1, 5'h04};
		return {2'h2, 5'h00};
	endfunction : exp_freq

	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task t_reset;
		rd(2'h0, rv);
		chk(rv, 8'h38, "control reset");
		rd(2'h2, rv);
		chk(rv, 8'h00, "tuning reset");
		chk(8'(multiplier_on), 8'h00, "multiplier reset");
		wait_src(osc_pkg::OSC_SRC_CONFIGURED, 6);
		$display("test reset done");
	endtask : t_reset

	task t_freq;
		for (int k = 0; k < 32; k++)
		begin
			wr(2'h0, {k[4], k[3:0], 3'h6});
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk(8'({internal_osc, div}), 8'(exp_freq(k[3:0], k[4])), "freq");
			chk(8'(multiplier_on), 8'(k[4]), "soft multiplier");
			chk(8'(clock_source), 8'(osc_pkg::OSC_SRC_INTERNAL), "internal source");
			rd(2'h0, rv);
			chk(rv, {k[4], k[3:0], 3'h2}, "control readback");
		end
		$display("test freq done");
	endtask : t_freq

	task t_status;
		@(posedge clk);
		tmr_en <= 1'b1;
		rdy <= 7'h35;
		wr(2'h0, 8'h38);
		repeat (5) @(posedge clk);
		rd(2'h1, rv);
		chk(rv, 8'h75, "status a");
		wr(2'h1, 8'h00);
		rd(2'h1, rv);
		chk(rv, 8'h75, "status write");
		@(posedge clk);
		tmr_en <= 1'b0;
		rdy <= 7'h0A;
		wr(2'h0, 8'h3A);
		repeat (5) @(posedge clk);
		rd(2'h1, rv);
		chk(rv, 8'h8A, "status b");
		@(posedge clk);
		tmr_en <= 1'b1;
		rdy <= 7'h4A;
		repeat (5) @(posedge clk);
		rd(2'h1, rv);
		chk(rv, 8'h8A, "status c");
		wr(2'h0, 8'h39);
		wait_src(osc_pkg::OSC_SRC_SECONDARY, 6);
		$display("test status done");
	endtask : t_status

	task t_tune;
		wr(2'h2, 8'hFF);
		rd(2'h2, rv);
		chk(rv, 8'h3F, "tune max");
		chk(8'(trim), 8'h3F, "trim out");
		wr(2'h2, 8'h20);
		rd(2'h2, rv);
		chk(8'(trim), 8'h20, "trim min");
		wr(2'h3, 8'hFF);
		rd(2'h3, rv);
		chk(rv, 8'h00, "unmapped read");
		rd(2'h0, rv);
		chk(rv, 8'h39, "control kept");
		$display("test tune done");
	endtask : t_tune

	task t_mult_start;
		do_reset(1'b1, 3'h1);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(8'(multiplier_on), 8'h01, "forced multiplier");
		chk(8'(clock_source), 8'(osc_pkg::OSC_SRC_STARTUP), "startup");
		edges(1023);
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(8'(clock_source), 8'(osc_pkg::OSC_SRC_STARTUP), "startup 1023");
		rd(2'h1, rv);
		chk(8'(rv[5]), 8'h00, "status not started");
		edges(1);
		wait_src(osc_pkg::OSC_SRC_CONFIGURED, 12);
		rd(2'h1, rv);
		chk(8'(rv[5]), 8'h01, "status started");
		@(posedge clk);
		fail <= 1'b1;
		wait_src(osc_pkg::OSC_SRC_INTERNAL, 8);
		chk(8'(internal_osc), 8'(osc_pkg::OSC_INT_MF), "fallback osc");
		@(posedge clk);
		fail <= 1'b0;
		wait_src(osc_pkg::OSC_SRC_CONFIGURED, 8);
		$display("test multiplier and startup done");
	endtask : t_mult_start

	initial
	begin
		rst_b = 1'b0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 2'h0;
		reg_wdata = 8'h00;
		cfg_mult = 1'b0;
		mode = 3'h4;
		tmr_en = 1'b0;
		osc_edge = 1'b0;
		fail = 1'b0;
		rdy = 7'h00;
		n_fail = 0;
		comparisons = 0;
		do_reset(1'b0, 3'h4);
		t_reset();
		t_freq();
		t_status();
		t_tune();
		t_mult_start();
		give_verdict();
	end
endmodule : test_osc_ctrl
`default_nettype wire
